// *** core/hrap_fifo.sv ***
// write path fifo of the host register access port
`timescale 1ns/1ns
`default_nettype none
module hrap_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rp_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    wp_d = push ? wp_q + 1'b1 : wp_q;
    rp_d = pop ? rp_q + 1'b1 : rp_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else if (clk_en) begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  // storage has no reset; out_valid is high only while entry rp_q holds a written value
  generate
    for (genvar i = 0; i < DEPTH; i++) begin : g_ent
      always_ff @(posedge sys_clk) begin
        if (clk_en && push && wp_q == AW'(i)) begin
          mem_q[i] <= in_data;
        end
      end
    end
  endgenerate
endmodule // hrap_fifo
`default_nettype wire

// *** core/hrap_port.sv ***
// host register access port: two-wire and six-wire slave engine
`timescale 1ns/1ns
`default_nettype none
module hrap_port import hrap_pkg::*; (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  // straps
  input wire logic strap_line_seven,
  input wire logic [6:0] strap_dev_addr,
  // link: scl or nibble clock
  input wire logic host_link_clk,
  // link: sda or framing select
  input wire logic host_frame_select_n_in,
  output logic host_frame_select_n_out,
  output logic host_frame_select_n_oe,
  // link: nibble bus
  input wire logic [3:0] host_nibble_bus_in,
  output logic [3:0] host_nibble_bus_out,
  output logic host_nibble_bus_oe,
  // register write side
  output logic reg_wr_valid,
  input wire logic reg_wr_ready,
  output logic [ADDR_W-1:0] reg_wr_addr,
  output logic [BYTE_W-1:0] reg_wr_data,
  // register read side
  output logic [ADDR_W-1:0] reg_rd_addr,
  input wire logic [BYTE_W-1:0] reg_rd_data,
  // status
  output logic six_wire_mode
);
  // ************************************************
  // synchronisers
  // ************************************************
  logic [5:0] lnk_m_q, lnk_s_q;
  logic lck_p_q, dat_p_q;
  logic [7:0] str_m_q, str_s_q;
  logic lck_s, dat_s;
  logic [3:0] nib_s;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      lnk_m_q <= 6'h3f;
      lnk_s_q <= 6'h3f;
      lck_p_q <= 1'b1;
      dat_p_q <= 1'b1;
    end else if (clk_en) begin
      lnk_m_q <= {host_link_clk, host_frame_select_n_in, host_nibble_bus_in};
      lnk_s_q <= lnk_m_q;
      lck_p_q <= lnk_s_q[5];
      dat_p_q <= lnk_s_q[4];
    end
  end
  // straps keep sampling through reset, so release finds them settled
  always_ff @(posedge sys_clk) begin
    if (clk_en) begin
      str_m_q <= {strap_line_seven, strap_dev_addr};
      str_s_q <= str_m_q;
    end
  end
  assign lck_s = lnk_s_q[5];
  assign dat_s = lnk_s_q[4];
  assign nib_s = lnk_s_q[3:0];
  // strap capture: first enabled edge after release
  logic cap_q, six_q, six_d;
  logic [6:0] dev_q, dev_d;
  always_comb begin
    six_d = cap_q ? six_q : str_s_q[7];
    dev_d = cap_q ? dev_q : str_s_q[6:0];
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cap_q <= 1'b0;
      six_q <= 1'b0;
      dev_q <= 7'h00;
    end else if (clk_en) begin
      cap_q <= 1'b1;
      six_q <= six_d;
      dev_q <= dev_d;
    end
  end
  assign six_wire_mode = six_q;
  // link events; state moves only on seen edges, so a paused clock is safe
  logic tw, sw, rise, fall, start_ev, stop_ev, fr_start, fr_off;
  assign tw = cap_q & ~six_q;
  assign sw = cap_q & six_q;
  assign rise = lck_s & ~lck_p_q;
  assign fall = ~lck_s & lck_p_q;
  assign start_ev = tw & lck_s & lck_p_q & dat_p_q & ~dat_s;
  assign stop_ev = tw & lck_s & lck_p_q & ~dat_p_q & dat_s;
  assign fr_start = sw & dat_p_q & ~dat_s;
  assign fr_off = sw & dat_s;

  // ************************************************
  // protocol engine
  // ************************************************
  hrap_state_t st_q, st_d;
  logic [3:0] bcnt_q, bcnt_d;
  logic [7:0] sh_q, sh_d, tx_q, tx_d;
  logic [8:0] ptr_q, ptr_d;
  logic inc_q, inc_d, rdop_q, rdop_d, first_q, first_d, acked_q, acked_d;
  logic oe_q, oe_d, noe_q, noe_d;
  logic [3:0] nib_q, nib_d;
  logic pend_q, pend_d;
  logic [16:0] pw_q, pw_d;
  logic take, ack;
  logic [7:0] bv;
  logic push_ready;
  always_comb begin
    st_d = st_q;
    bcnt_d = bcnt_q;
    sh_d = sh_q;
    tx_d = tx_q;
    ptr_d = ptr_q;
    inc_d = inc_q;
    rdop_d = rdop_q;
    first_d = first_q;
    acked_d = acked_q;
    oe_d = oe_q;
    noe_d = noe_q;
    nib_d = nib_q;
    pend_d = pend_q & ~push_ready & ~fr_off;
    pw_d = pw_q;
    take = 1'b0;
    bv = sh_q;
    ack = 1'b0;
    if (start_ev | fr_start) begin
      st_d = tw ? ST_DEVADDR : ST_INSTR;
      bcnt_d = 4'h0;
      oe_d = 1'b0;
      noe_d = 1'b0;
    end else if (stop_ev | fr_off) begin
      st_d = ST_IDLE;
      bcnt_d = 4'h0;
      oe_d = 1'b0;
      noe_d = 1'b0;
    end else if (tw && st_q != ST_IDLE) begin
      if (rise && bcnt_q < BIT_ACK) begin
        sh_d = {sh_q[6:0], dat_s};
        tx_d = {tx_q[6:0], 1'b1};
        bcnt_d = bcnt_q + 4'h1;
      end else if (rise && bcnt_q == BIT_ACK) begin
        acked_d = ~dat_s;
        bcnt_d = BIT_END;
        if (st_q == ST_READ && inc_q && !first_q) begin
          ptr_d = ptr_q + PTR_ONE;
        end
      end else if (fall && bcnt_q == BIT_ACK) begin
        if (st_q == ST_READ) begin
          oe_d = 1'b0;
        end else begin
          take = 1'b1;
        end
      end else if (fall && bcnt_q == BIT_END) begin
        oe_d = 1'b0;
        bcnt_d = 4'h0;
        if (st_q == ST_READ) begin
          if (first_q | acked_q) begin
            tx_d = reg_rd_data;
            oe_d = ~reg_rd_data[7];
            first_d = 1'b0;
          end else begin
            st_d = ST_IGNORE;
          end
        end
      end else if (fall && st_q == ST_READ) begin
        oe_d = ~tx_q[7];
      end
    end else if (sw && st_q != ST_IDLE) begin
      if (fall && st_q != ST_READ) begin
        sh_d = {sh_q[3:0], nib_s};
        bcnt_d = {3'h0, ~bcnt_q[0]};
        take = bcnt_q[0];
        bv = {sh_q[3:0], nib_s};
      end else if (rise && st_q == ST_READ) begin
        bcnt_d = {3'h0, ~bcnt_q[0]};
        if (!bcnt_q[0]) begin
          tx_d = reg_rd_data;
          nib_d = reg_rd_data[7:4];
        end else begin
          nib_d = tx_q[3:0];
          if (inc_q) begin
            ptr_d = ptr_q + PTR_ONE;
          end
        end
      end
    end
    if (take) begin
      ack = (st_q != ST_IGNORE) && tw;
      unique case (st_q)
        ST_DEVADDR: begin
          if (bv[7:1] == dev_q) begin
            st_d = bv[0] ? ST_READ : ST_INSTR;
            first_d = 1'b1;
          end else begin
            st_d = ST_IGNORE;
            ack = 1'b0;
          end
        end
        ST_INSTR: begin
          st_d = ST_ADDR;
          ptr_d[8] = bv[0];
          unique case (bv[7:4])
            OP_WR_INC: begin
              inc_d = 1'b1;
              rdop_d = 1'b0;
            end
            OP_WR_FIX: begin
              inc_d = 1'b0;
              rdop_d = 1'b0;
            end
            OP_RD_INC: begin
              inc_d = 1'b1;
              rdop_d = 1'b1;
            end
            OP_RD_FIX: begin
              inc_d = 1'b0;
              rdop_d = 1'b1;
            end
            default: begin
              st_d = ST_IGNORE;
              ptr_d = ptr_q;
            end
          endcase
        end
        ST_ADDR: begin
          ptr_d[7:0] = bv;
          // two-wire reads resume after a repeated start as a direct read
          st_d = rdop_q ? (sw ? ST_READ : ST_IGNORE) : ST_WRITE;
          noe_d = rdop_q & sw;
        end
        ST_WRITE: begin
          // a byte landing while the last one still waits is lost
          if (!pend_d) begin
            pend_d = 1'b1;
            pw_d = {ptr_q, bv};
          end
          if (inc_q) begin
            ptr_d = ptr_q + PTR_ONE;
          end
        end
        default: st_d = st_q;
      endcase
      oe_d = ack;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_q <= ST_IDLE;
      bcnt_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'hff;
      ptr_q <= PTR_RST;
      inc_q <= 1'b0;
      rdop_q <= 1'b0;
      first_q <= 1'b0;
      acked_q <= 1'b0;
      oe_q <= 1'b0;
      noe_q <= 1'b0;
      nib_q <= 4'hf;
      pend_q <= 1'b0;
      pw_q <= 17'h00000;
    end else if (clk_en) begin
      st_q <= st_d;
      bcnt_q <= bcnt_d;
      sh_q <= sh_d;
      tx_q <= tx_d;
      ptr_q <= ptr_d;
      inc_q <= inc_d;
      rdop_q <= rdop_d;
      first_q <= first_d;
      acked_q <= acked_d;
      oe_q <= oe_d;
      noe_q <= noe_d;
      nib_q <= nib_d;
      pend_q <= pend_d;
      pw_q <= pw_d;
    end
  end

  assign host_frame_select_n_out = 1'b0;
  assign host_frame_select_n_oe = oe_q;
  assign host_nibble_bus_out = nib_q;
  assign host_nibble_bus_oe = noe_q;
  assign reg_rd_addr = ptr_q;

  // ************************************************
  // write buffer
  // ************************************************
  logic [16:0] fo_data;
  hrap_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
    .in_valid(pend_q), .in_ready(push_ready), .in_data(pw_q),
    .out_valid(reg_wr_valid), .out_ready(reg_wr_ready), .out_data(fo_data)
  );
  assign reg_wr_addr = fo_data[16:8];
  assign reg_wr_data = fo_data[7:0];

  // ************************************************
  // checks
  // ************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence s_ack_edge;
    clk_en && take && tw && st_q == ST_INSTR;
  endsequence
  chk_nop_ptr_hold: assert property (clk_en && st_q == ST_IGNORE
    && !start_ev && !fr_start |=> $stable(ptr_q) && !$rose(pend_q))
    else $error("pointer moved during ignored transfer");
  chk_start_parse: assert property (clk_en && start_ev
    |=> st_q == ST_DEVADDR && bcnt_q == 4'h0)
    else $error("start did not open address phase");
  chk_stop_idle: assert property (clk_en && stop_ev
    |=> st_q == ST_IDLE && !host_frame_select_n_oe)
    else $error("stop did not end transfer");
  chk_ack_drive: assert property (s_ack_edge
    |=> host_frame_select_n_oe)
    else $error("received byte not acknowledged");
  chk_sda_low_scl: assert property (tw && $changed(oe_q)
    |-> !$past(lck_s))
    else $error("sda moved while scl high");
  chk_frame_ignore: assert property (clk_en && fr_off
    |=> !host_nibble_bus_oe && st_q == ST_IDLE)
    else $error("activity seen with framing high");
  chk_frame_start: assert property (clk_en && fr_start
    |=> st_q == ST_INSTR && !host_nibble_bus_oe)
    else $error("framing did not restart port");
  chk_write_inc: assert property (clk_en && take && st_q == ST_WRITE
    |=> ptr_q == $past(ptr_q) + {8'h00, $past(inc_q)})
    else $error("write pointer step wrong");
  chk_nib_on_rise: assert property ($changed(nib_q)
    |-> $past(rise) && $past(sw))
    else $error("nibble driven off rising edge");
  chk_mode_held: assert property (cap_q |=> $stable(six_q))
    else $error("mode changed after capture");
endmodule // hrap_port
`default_nettype wire

// *** dv/hrap_host_model.sv ***
// host master model for the host register access port link
`timescale 1ns/1ns
`default_nettype none
module hrap_host_model (
  // clock
  input wire logic sys_clk,
  // resolved link lines
  input wire logic line,
  input wire logic [3:0] nib,
  // host side drive
  output logic link_clk,
  output logic line_low,
  output logic nib_oe,
  output logic [3:0] nib_out
);
  // ****************************************
  // idle levels
  // ****************************************
  initial begin
    link_clk = 1'b1;
    line_low = 1'b0;
    nib_oe = 1'b0;
    nib_out = 4'hf;
  end

  task automatic w(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // ****************************************
  // two-wire, 320 ns clock period
  // ****************************************
  task automatic tw_start();
    w(2);
    line_low <= 1'b0;
    w(2);
    link_clk <= 1'b1;
    w(2);
    line_low <= 1'b1;
    w(2);
    link_clk <= 1'b0;
  endtask

  task automatic tw_stop();
    w(2);
    line_low <= 1'b1;
    w(2);
    link_clk <= 1'b1;
    w(2);
    line_low <= 1'b0;
    w(4);
  endtask

  // data moves mid-low so the slave never sees a false start or stop
  task automatic tw_bit(input logic b, output logic r);
    w(2);
    line_low <= ~b;
    w(2);
    link_clk <= 1'b1;
    w(4);
    r = line;
    link_clk <= 1'b0;
  endtask

  task automatic tw_wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      tw_bit(d[i], r);
    end
    tw_bit(1'b1, r);
    ack = ~r;
  endtask

  task automatic tw_rd(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      tw_bit(1'b1, d[i]);
    end
    tw_bit(~ack, r);
  endtask

  // ****************************************
  // six-wire, one twentieth of sys_clk
  // ****************************************
  task automatic sw_frame(input logic on);
    w(10);
    line_low <= on;
    nib_oe <= 1'b0;
    w(10);
  endtask

  task automatic sw_wr(input logic [7:0] d);
    for (int i = 1; i >= 0; i--) begin
      nib_oe <= 1'b1;
      nib_out <= d[i*4+:4];
      w(10);
      link_clk <= 1'b0;
      w(10);
      link_clk <= 1'b1;
    end
  endtask

  task automatic sw_rd(output logic [7:0] d);
    nib_oe <= 1'b0;
    for (int i = 1; i >= 0; i--) begin
      w(10);
      d[i*4+:4] = nib;
      link_clk <= 1'b0;
      w(10);
      link_clk <= 1'b1;
    end
  endtask
endmodule // hrap_host_model
`default_nettype wire

// *** dv/tb.sv ***
// self-checking testbench of the host register access port
`timescale 1ns/1ns
`default_nettype none
module tb;
  import hrap_pkg::*;
  logic sys_clk, reset, strap, ready, en;
  logic [6:0] dev;
  logic link_clk, line_low, h_oe, fs_out, fs_oe, nb_oe, wr_valid, six;
  logic [3:0] h_out, nb_out;
  logic [8:0] wr_addr, rd_addr;
  logic [7:0] wr_data, d;
  logic [7:0] regs [512];
  logic [16:0] wlog [$];
  logic a;
  int error_cnt, n_checks, cyc;
  // open drain line with pull-up, nibble bus with pull-ups
  wire logic line = ~(line_low | (fs_oe & ~fs_out));
  wire logic [3:0] nib = nb_oe ? nb_out : (h_oe ? h_out : 4'hf);
  wire logic [7:0] rd_data = regs[rd_addr];

  hrap_port dut_u (.sys_clk(sys_clk), .reset(reset), .clk_en(en),
    .strap_line_seven(strap), .strap_dev_addr(dev),
    .host_link_clk(link_clk), .host_frame_select_n_in(line),
    .host_frame_select_n_out(fs_out), .host_frame_select_n_oe(fs_oe),
    .host_nibble_bus_in(nib), .host_nibble_bus_out(nb_out),
    .host_nibble_bus_oe(nb_oe), .reg_wr_valid(wr_valid),
    .reg_wr_ready(ready), .reg_wr_addr(wr_addr), .reg_wr_data(wr_data),
    .reg_rd_addr(rd_addr), .reg_rd_data(rd_data), .six_wire_mode(six));

  hrap_host_model host_u (.sys_clk(sys_clk), .line(line), .nib(nib),
    .link_clk(link_clk), .line_low(line_low), .nib_oe(h_oe),
    .nib_out(h_out));

  // ****************************************
  // clock, register file, watchdog
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (reset === 1'b0 && wr_valid === 1'b1 && ready === 1'b1) begin
      regs[wr_addr] <= wr_data;
      wlog.push_back({wr_addr, wr_data});
    end
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      error_cnt++;
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic do_reset(input logic mode);
    reset <= 1'b1;
    strap <= mode;
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (6) @(posedge sys_clk);
  endtask

  task automatic exp_wr(input logic [8:0] ad, input logic [7:0] dt);
    logic [16:0] e;
    e = (wlog.size() > 0) ? wlog.pop_front() : 17'h1ffff;
    check("write", {15'h0, e}, {15'h0, ad, dt});
  endtask

  task automatic wb(input logic [7:0] dt, input logic exp);
    host_u.tw_wr(dt, a);
    check("ack", {31'h0, a}, {31'h0, exp});
  endtask

  task automatic hdr(input logic [7:0] op, input logic [7:0] ad);
    host_u.tw_start();
    wb(8'h54, 1'b1);
    wb(op, 1'b1);
    wb(ad, 1'b1);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_tw_write();
    hdr(8'h11, 8'hfe);
    wb(8'ha1, 1'b1);
    wb(8'ha2, 1'b1);
    host_u.tw_stop();
    exp_wr(9'h1fe, 8'ha1);
    exp_wr(9'h1ff, 8'ha2);
    hdr(8'h20, 8'h10);
    wb(8'hb1, 1'b1);
    wb(8'hb2, 1'b1);
    host_u.tw_stop();
    exp_wr(9'h010, 8'hb1);
    exp_wr(9'h010, 8'hb2);
    $display("test two-wire write done");
  endtask

  task automatic t_tw_read();
    hdr(8'h90, 8'h10);
    host_u.tw_start();
    wb(8'h55, 1'b1);
    host_u.tw_rd(1'b1, d);
    check("rd0", d, 8'hb2);
    host_u.tw_rd(1'b0, d);
    check("rd1", d, 8'h4b);
    host_u.tw_stop();
    host_u.tw_start();
    wb(8'h55, 1'b1);
    host_u.tw_rd(1'b0, d);
    check("direct", d, 8'h48);
    host_u.tw_stop();
    $display("test two-wire read done");
  endtask

  task automatic t_tw_refuse();
    host_u.tw_start();
    wb(8'h2a, 1'b0);
    host_u.tw_stop();
    host_u.tw_start();
    wb(8'h54, 1'b1);
    wb(8'h01, 1'b1);
    wb(8'h77, 1'b0);
    host_u.tw_stop();
    host_u.w(20);
    check("nowrite", wlog.size(), 0);
    $display("test two-wire refuse done");
  endtask

  task automatic t_sw_write();
    do_reset(1'b1);
    check("mode", six, 1'b1);
    host_u.sw_wr(8'h10);
    check("ignored", wlog.size(), 0);
    check("idle oe", nb_oe, 1'b0);
    ready <= 1'b0;
    host_u.sw_frame(1'b1);
    host_u.sw_wr(8'h10);
    host_u.sw_wr(8'h80);
    for (int i = 0; i < 9; i++) begin
      host_u.sw_wr(8'hd0 + 8'(i));
    end
    host_u.sw_frame(1'b0);
    check("full", wr_valid, 1'b1);
    ready <= 1'b1;
    host_u.w(20);
    for (int i = 0; i < 8; i++) begin
      exp_wr(9'h080 + 9'(i), 8'hd0 + 8'(i));
    end
    check("dropped", wlog.size(), 0);
    $display("test six-wire write done");
  endtask

  task automatic t_sw_read();
    host_u.sw_frame(1'b1);
    host_u.sw_wr(8'ha0);
    host_u.sw_wr(8'h80);
    host_u.sw_rd(d);
    check("srd0", d, 8'hd0);
    host_u.sw_rd(d);
    check("srd1", d, 8'hd0);
    host_u.sw_frame(1'b0);
    check("end oe", nb_oe, 1'b0);
    $display("test six-wire read done");
  endtask

  task automatic t_freeze();
    en <= 1'b0;
    host_u.tw_start();
    wb(8'h54, 1'b0);
    check("frozen oe", fs_oe, 1'b0);
    en <= 1'b1;
    host_u.tw_stop();
    $display("test clock enable freeze done");
  endtask

  task automatic t_tw_strap();
    dev <= 7'h15;
    do_reset(1'b0);
    check("mode", six, 1'b0);
    host_u.tw_start();
    wb(8'h54, 1'b0);
    host_u.tw_stop();
    host_u.tw_start();
    wb(8'h2a, 1'b1);
    wb(8'h00, 1'b1);
    wb(8'h33, 1'b0);
    host_u.tw_stop();
    host_u.w(20);
    check("spare", wlog.size(), 0);
    $display("test two-wire strap done");
  endtask

  initial begin
    reset = 1'b1;
    strap = 1'b0;
    dev = 7'h2a;
    ready = 1'b1;
    en = 1'b1;
    for (int i = 0; i < 512; i++) begin
      regs[i] = 8'(i) ^ 8'h5a;
    end
    do_reset(1'b0);
    t_tw_write();
    t_tw_read();
    t_freeze();
    t_tw_refuse();
    t_sw_write();
    t_sw_read();
    t_tw_strap();
    finish_test();
  end
endmodule // tb
`default_nettype wire

// *** include/hrap_pkg.sv ***
// constants and types of the host register access port
//
// Operation
// - upper nibble zero instruction: no register operation, contents unchanged
// - two-wire start: sda falls while scl high, begins a transfer
// - two-wire transfer ends on stop or repeated start
// - sda changes only while scl low, stable while scl high
// - two-wire bytes are eight bits, msb first, unlimited count
// - device pulls sda low in ninth clock after each received byte; bytes of an ignored transfer get no ack
// - incrementing write advances pointer per byte; fixed write reuses address
// - incrementing read advances pointer per byte sent; fixed read repeats
// - direct read advances only if last instruction was incrementing
// - six-wire slave moves four bits per edge; master makes clock
// - nibble clock at most one twentieth of oversampling clock
// - mode strap latched at reset release; one means six-wire
// - framing high: ignore nibble clock and data
// - framing fall starts transfer; framing rise clears pending operation
// - six-wire samples on clock fall, drives on clock rise
// - six-wire bytes are two nibbles, high nibble first, unlimited
// - six-wire port is static; clock may pause anywhere
// - instruction lsb is address bit nine, increments with pointer
// - codes: 1 inc write, 2 fixed write, 9 inc read, a fixed read
// - two-wire answers only strapped seven-bit address
// - six-wire: no ack, no device address, first byte is instruction
package hrap_pkg;
  localparam int ADDR_W = 9;
  localparam int BYTE_W = 8;
  localparam int FIFO_W = ADDR_W + BYTE_W;
  localparam int FIFO_DEPTH = 8;
  localparam int CLK_RATIO_MIN = 20;
  localparam logic [3:0] OP_WR_INC = 4'h1;
  localparam logic [3:0] OP_WR_FIX = 4'h2;
  localparam logic [3:0] OP_RD_INC = 4'h9;
  localparam logic [3:0] OP_RD_FIX = 4'ha;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_END = 4'h9;
  localparam logic [8:0] PTR_RST = 9'h000;
  localparam logic [8:0] PTR_ONE = 9'h001;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DEVADDR = 3'b001,
    ST_INSTR = 3'b010,
    ST_ADDR = 3'b011,
    ST_WRITE = 3'b100,
    ST_READ = 3'b101,
    ST_IGNORE = 3'b110
  } hrap_state_t;
endpackage
